/* verilog/host_port_pkg.sv */
// constants for the host-port pin control block
// assumes a single 20 MHz clock and an AXI4-Lite master for software access
//
// Contract
// - ready pin tells the host whether the next transfer can be accepted
// - ready pin serves the host port only while ext_io_mode_select is low
// - ready pin floats whenever output_disable_n is low
// - each subsystem interrupts the host by driving its interrupt pin low
// - host writes one to clear bit; device then releases the interrupt pin
// - host interrupts exist only in multiplexed mode, host_mode_select low
// - both interrupt pins float whenever output_disable_n is low
// - host_port_reset_n resets host port logic and both subsystems
// - host_mode_select low selects multiplexed address/data operation
// - multiplexed host reaches space only via control, address, data registers
// - multiplexed mode supports interrupts host to subsystem and back
// - nonmultiplexed host uses 18-bit address bus and 16-bit data bus
// - nonmultiplexed mode gives no interrupts in either direction
`default_nettype none

package host_port_pkg;
   // register byte offsets
   localparam logic [3:0] OFS_CTRL = 4'h0;
   localparam logic [3:0] OFS_STATUS = 4'h4;
   localparam logic [3:0] OFS_IRQ_STAT = 4'h8;
   localparam logic [3:0] OFS_IRQ_MASK = 4'hC;
   // control register fields
   localparam int CTRL_RAISE_A = 0;
   localparam int CTRL_RAISE_B = 1;
   localparam int CTRL_BUSY = 2;
   // event bits
   localparam int EV_HOST_CLR_A = 0;
   localparam int EV_HOST_CLR_B = 1;
   localparam int EV_HOST_TO_SUB = 2;
   localparam int EV_PORT_RESET = 3;
   localparam int EV_W = 4;
   localparam logic [2:0] CTRL_RESET = 3'h0;
   localparam logic [EV_W-1:0] MASK_RESET = 4'h0;
   localparam int HOST_ADDR_W = 18;
   localparam int HOST_DATA_W = 16;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : host_port_pkg

`default_nettype wire

/* verilog/host_port_pin_control.sv */
// host-port pin control: ready, host interrupts, port reset, mode, tristate
// assumes all pins synchronous to MCLK; pads resolve the _OE outputs
// registers: 0x0 control, 0x4 status, 0x8 event status, 0xc event mask
`default_nettype none

module host_port_pin_control (
   input wire logic MCLK,
   input wire logic SYS_RST,
   input wire logic CLK_EN,
   // host-side pins
   input wire logic HOST_PORT_RESET_N,
   input wire logic HOST_MODE_SELECT,
   input wire logic EXT_IO_MODE_SELECT,
   input wire logic OUTPUT_DISABLE_N,
   input wire logic HOST_INT_CLEAR_A,
   input wire logic HOST_INT_CLEAR_B,
   input wire logic HOST_TO_SUB_REQ,
   output logic HOST_READY_OUT,
   output logic HOST_READY_OE,
   output logic HOST_INTERRUPT_OUT,
   output logic HOST_INTERRUPT_OE,
   output logic HOST_INTERRUPT_OUT_SECOND,
   output logic HOST_INTERRUPT_OE_SECOND,
   output logic SUBSYS_RESET,
   output logic IRQ,
   // AXI4-Lite slave
   input wire logic [3:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [3:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY
);

   ////////////////////////////////////////////////////////////////////////////
   // register state
   logic [2:0] ctrl;
   logic [1:0] ctrl_q;
   logic [3:0] irq_stat;
   logic [3:0] irq_mask;
   logic [1:0] pend;

   // write channel holding registers
   logic [3:0] aw_addr;
   logic aw_held;
   logic w_held;
   logic [31:0] w_data;
   logic [3:0] w_strb;

   // read channel
   logic [3:0] ar_addr;

   // decoded pin and bus state
   logic port_rst;
   logic mux_mode;
   logic wr_go;
   logic rd_go;
   logic [3:0] ev;

   ////////////////////////////////////////////////////////////////////////////
   // only the four word addresses answer; anything else gets an error response
   function automatic logic mapped(input logic [3:0] a);
      mapped = (a == host_port_pkg::OFS_CTRL) || (a == host_port_pkg::OFS_STATUS)
         || (a == host_port_pkg::OFS_IRQ_STAT) || (a == host_port_pkg::OFS_IRQ_MASK);
   endfunction : mapped

   // both interrupt pins share one enable decode
   function automatic logic int_oe(input logic drive_ok, input logic mode);
      int_oe = drive_ok && mode;
   endfunction : int_oe

   ////////////////////////////////////////////////////////////////////////////
   // the port reset pin clears port logic together with the subsystems
   assign port_rst = SYS_RST | ~HOST_PORT_RESET_N;

   // the host bus itself lives outside this block; only the mode it runs in
   // matters here, as it gates the interrupt paths both ways
   assign mux_mode = ~HOST_MODE_SELECT;

   assign wr_go = aw_held && w_held && !S_AXI_BVALID;
   assign rd_go = S_AXI_ARVALID && S_AXI_ARREADY;

   ////////////////////////////////////////////////////////////////////////////
   // write path: address and data accepted in either order
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 4'h0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         S_AXI_AWREADY <= 1'b0;
         S_AXI_WREADY <= 1'b0;
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP <= host_port_pkg::RESP_OKAY;
      end else if (CLK_EN) begin
         S_AXI_AWREADY <= !aw_held && !S_AXI_AWREADY && S_AXI_AWVALID;
         S_AXI_WREADY <= !w_held && !S_AXI_WREADY && S_AXI_WVALID;

         if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_held <= 1'b1;
            aw_addr <= S_AXI_AWADDR;
         end
         if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_held <= 1'b1;
            w_data <= S_AXI_WDATA;
            w_strb <= S_AXI_WSTRB;
         end

         // a new response waits until the previous one has been taken
         if (wr_go) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= mapped(aw_addr) ? host_port_pkg::RESP_OKAY
               : host_port_pkg::RESP_SLVERR;
         end else if (S_AXI_BVALID && S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read path
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA <= 32'h0000_0000;
         S_AXI_RRESP <= host_port_pkg::RESP_OKAY;
         ar_addr <= 4'h0;
      end else if (CLK_EN) begin
         S_AXI_ARREADY <= !S_AXI_ARREADY && !S_AXI_RVALID && S_AXI_ARVALID;

         // read data is captured once, so status bits cannot move under the master
         if (rd_go) begin
            ar_addr <= S_AXI_ARADDR;
            S_AXI_RVALID <= 1'b1;
            S_AXI_RRESP <= mapped(S_AXI_ARADDR) ? host_port_pkg::RESP_OKAY
               : host_port_pkg::RESP_SLVERR;
            case (S_AXI_ARADDR)
               host_port_pkg::OFS_CTRL: S_AXI_RDATA <= {29'h0, ctrl};
               host_port_pkg::OFS_STATUS: S_AXI_RDATA <= {26'h0, mux_mode,
                  ~EXT_IO_MODE_SELECT, OUTPUT_DISABLE_N, port_rst, pend};
               host_port_pkg::OFS_IRQ_STAT: S_AXI_RDATA <= {28'h0, irq_stat};
               host_port_pkg::OFS_IRQ_MASK: S_AXI_RDATA <= {28'h0, irq_mask};
               default: S_AXI_RDATA <= 32'h0000_0000;
            endcase
         end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // control and mask registers
   always_ff @(posedge MCLK) begin
      if (port_rst) begin
         ctrl <= host_port_pkg::CTRL_RESET;
      end else if (CLK_EN && wr_go && w_strb[0] && aw_addr == host_port_pkg::OFS_CTRL) begin
         ctrl <= w_data[2:0];
      end
   end

   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         irq_mask <= host_port_pkg::MASK_RESET;
      end else if (CLK_EN && wr_go && w_strb[0]
            && aw_addr == host_port_pkg::OFS_IRQ_MASK) begin
         irq_mask <= w_data[3:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pending host interrupts, one per subsystem
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : gen_pend
         logic raise;
         logic clear;
         assign raise = ctrl[g] && mux_mode;
         assign clear = (g == 0) ? HOST_INT_CLEAR_A : HOST_INT_CLEAR_B;
         always_ff @(posedge MCLK) begin
            if (port_rst) begin
               pend[g] <= 1'b0;
            end else if (CLK_EN) begin
               // a new raise wins over a host clear in the same cycle
               if (!mux_mode) begin
                  pend[g] <= 1'b0;
               end else if (raise && !ctrl_q[g]) begin
                  pend[g] <= 1'b1;
               end else if (clear) begin
                  pend[g] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   // edge detect on the raise bits; leaving mux mode rearms them
   always_ff @(posedge MCLK) begin
      if (port_rst) begin
         ctrl_q <= 2'h0;
      end else if (CLK_EN) begin
         ctrl_q <= ctrl[1:0] & {2{mux_mode}};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sticky events, cleared by reading the event status register
   assign ev[host_port_pkg::EV_HOST_CLR_A] = HOST_INT_CLEAR_A && pend[0];
   assign ev[host_port_pkg::EV_HOST_CLR_B] = HOST_INT_CLEAR_B && pend[1];
   assign ev[host_port_pkg::EV_HOST_TO_SUB] = HOST_TO_SUB_REQ && mux_mode;
   assign ev[host_port_pkg::EV_PORT_RESET] = ~HOST_PORT_RESET_N;

   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         irq_stat <= 4'h0;
         IRQ <= 1'b0;
      end else if (CLK_EN) begin
         // set wins over the read clear
         if (rd_go && S_AXI_ARADDR == host_port_pkg::OFS_IRQ_STAT) begin
            irq_stat <= ev;
         end else begin
            irq_stat <= irq_stat | ev;
         end
         IRQ <= |(irq_stat & irq_mask);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // ready pin; not ready while in reset or busy
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         HOST_READY_OUT <= 1'b0;
         HOST_READY_OE <= 1'b0;
      end else if (CLK_EN) begin
         HOST_READY_OUT <= !port_rst && !ctrl[host_port_pkg::CTRL_BUSY];
         // the shared pin belongs to the memory interface while ext_io mode is high
         HOST_READY_OE <= OUTPUT_DISABLE_N && !EXT_IO_MODE_SELECT;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupt pins, active low; they float when outputs are disabled
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         HOST_INTERRUPT_OUT <= 1'b1;
         HOST_INTERRUPT_OE <= 1'b0;
         HOST_INTERRUPT_OUT_SECOND <= 1'b1;
         HOST_INTERRUPT_OE_SECOND <= 1'b0;
      end else if (CLK_EN) begin
         HOST_INTERRUPT_OUT <= !pend[0];
         HOST_INTERRUPT_OE <= int_oe(OUTPUT_DISABLE_N, mux_mode);
         HOST_INTERRUPT_OUT_SECOND <= !pend[1];
         HOST_INTERRUPT_OE_SECOND <= int_oe(OUTPUT_DISABLE_N, mux_mode);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // subsystem reset follows the port reset one cycle later
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         SUBSYS_RESET <= 1'b1;
      end else if (CLK_EN) begin
         SUBSYS_RESET <= port_rst;
      end
   end

endmodule : host_port_pin_control

`default_nettype wire

/* bench/host_port_pin_control_properties.sv */
// concurrent checks on the host-port pin control top-level ports
// assumes a single MCLK domain and SYS_RST as its synchronous reset
`default_nettype none

module host_port_checker (
   input wire logic MCLK,
   input wire logic SYS_RST,
   input wire logic CLK_EN,
   input wire logic HOST_PORT_RESET_N,
   input wire logic HOST_MODE_SELECT,
   input wire logic EXT_IO_MODE_SELECT,
   input wire logic OUTPUT_DISABLE_N,
   input wire logic HOST_INT_CLEAR_A,
   input wire logic S_AXI_WVALID,
   input wire logic HOST_READY_OUT,
   input wire logic HOST_READY_OE,
   input wire logic HOST_INTERRUPT_OUT,
   input wire logic HOST_INTERRUPT_OE,
   input wire logic HOST_INTERRUPT_OUT_SECOND,
   input wire logic HOST_INTERRUPT_OE_SECOND,
   input wire logic SUBSYS_RESET
);
   default clocking @(posedge MCLK); endclocking
   default disable iff (SYS_RST);
////////////////////////////////////////////////////////////////////////////////
   property p_rdy_rise; $rose(HOST_READY_OUT) |-> $past(HOST_PORT_RESET_N); endproperty
   a_rdy_rise: assert property (p_rdy_rise) else $error("ready rose in port reset");
   property p_rdy_ext; CLK_EN && EXT_IO_MODE_SELECT |=> !HOST_READY_OE; endproperty
   a_rdy_ext: assert property (p_rdy_ext) else $error("ready driven in memory mode");
   property p_off; CLK_EN && !OUTPUT_DISABLE_N
      |=> !(HOST_READY_OE || HOST_INTERRUPT_OE || HOST_INTERRUPT_OE_SECOND); endproperty
   a_off: assert property (p_off) else $error("pin driven while disabled");
   property p_int_low; $fell(HOST_INTERRUPT_OUT)
      |-> !$past(HOST_MODE_SELECT) || !$past(HOST_MODE_SELECT, 2); endproperty
   a_int_low: assert property (p_int_low) else $error("interrupt outside mux mode");
   // three cycles, so a raise taken just before the clear has had its turn
   property p_clr; (CLK_EN && HOST_INT_CLEAR_A && !S_AXI_WVALID)[*3]
      |=> HOST_INTERRUPT_OUT; endproperty
   a_clr: assert property (p_clr) else $error("interrupt not released");
   property p_nonmux; (CLK_EN && HOST_MODE_SELECT)[*2]
      |=> HOST_INTERRUPT_OUT && HOST_INTERRUPT_OUT_SECOND; endproperty
   a_nonmux: assert property (p_nonmux) else $error("interrupt in nonmux mode");
   property p_port_rst; CLK_EN && !HOST_PORT_RESET_N |=> SUBSYS_RESET && !HOST_READY_OUT; endproperty
   a_port_rst: assert property (p_port_rst) else $error("port reset ignored");
   property p_mux_oe; CLK_EN && OUTPUT_DISABLE_N && !HOST_MODE_SELECT
      |=> HOST_INTERRUPT_OE; endproperty
   a_mux_oe: assert property (p_mux_oe) else $error("interrupt pin idle in mux");
endmodule : host_port_checker

bind host_port_pin_control host_port_checker host_port_checker_inst (.*);

`default_nettype wire

/* bench/host_model.sv */
// host processor model driving the clear and request pins
// assumes bench commands in the MCLK domain
`default_nettype none

module host_model (
   input wire logic MCLK,
   input wire logic ready,
   input wire logic slow,
   input wire logic [2:0] req,
   output logic [2:0] pins
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] dly;
   // a busy port holds the host off; slow answers one cycle later
   always_ff @(posedge MCLK) begin
      dly <= req;
      pins <= ready ? (slow ? dly : req) : 3'h0;
   end
endmodule : host_model

`default_nettype wire

/* bench/testbench.sv */
// self-checking bench for host_port_pin_control
// assumes the checker is bound in and host_model drives the clear and request pins
`default_nettype none

module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst = 1, prn = 1, hms = 0, ext = 0, odn = 1, slow = 0;
   logic [2:0] req = 0, pins;
   logic [3:0] awa = 0, ara = 0;
   logic [31:0] wd = 0, rdata;
   logic awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
   logic awr, wr, bv, arr, rv, rdy, rdy_oe, ia, ia_oe, ib, ib_oe, sub, irq;
   logic [1:0] bresp, rresp;
   logic [7:0] seed = 8'h3A;
   int n_mismatch = 0, n_compared = 0;
   initial forever #25 clk = ~clk;
   host_model host_model_inst (.MCLK(clk), .ready(rdy), .slow(slow), .req(req), .pins(pins));
   host_port_pin_control host_port_pin_control_inst (.MCLK(clk), .SYS_RST(rst),
      .CLK_EN(1'h1), .HOST_PORT_RESET_N(prn), .HOST_MODE_SELECT(hms),
      .EXT_IO_MODE_SELECT(ext), .OUTPUT_DISABLE_N(odn), .HOST_INT_CLEAR_A(pins[0]),
      .HOST_INT_CLEAR_B(pins[1]), .HOST_TO_SUB_REQ(pins[2]), .HOST_READY_OUT(rdy),
      .HOST_READY_OE(rdy_oe), .HOST_INTERRUPT_OUT(ia), .HOST_INTERRUPT_OE(ia_oe),
      .HOST_INTERRUPT_OUT_SECOND(ib), .HOST_INTERRUPT_OE_SECOND(ib_oe),
      .SUBSYS_RESET(sub), .IRQ(irq), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
      .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv),
      .S_AXI_WREADY(wr), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(br),
      .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr));
////////////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] lfsr(logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr
   task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
      n_compared++;
      if (s !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic final_report;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : final_report
   task automatic tmo(int n);
      if (n >= 64) begin
         n_mismatch++;
         final_report();
      end
   endtask : tmo
   // only the aligned word addresses exist; the rest answer with an error
   function automatic logic [1:0] exp_resp(logic [3:0] a);
      return (a[1:0] == 2'h0) ? host_port_pkg::RESP_OKAY : host_port_pkg::RESP_SLVERR;
   endfunction : exp_resp
   task automatic axw(logic [3:0] a, logic [31:0] d);
      int n;
      awa <= a;
      wd <= d;
      {awv, wv, br} <= 3'h7;
      for (n = 0; n < 64; n++) begin
         @(posedge clk);
         if (!awv && !wv && !br) break;
         if (awr) awv <= 0;
         if (wr) wv <= 0;
         if (bv && br) begin
            br <= 0;
            chk("bresp", bresp, exp_resp(a));
         end
      end
      tmo(n);
   endtask : axw
   task automatic axr(logic [3:0] a, logic [31:0] e, string nm);
      int n;
      ara <= a;
      {arv, rr} <= 2'h3;
      for (n = 0; n < 64; n++) begin
         @(posedge clk);
         if (!arv && !rr) break;
         if (arr) arv <= 0;
         if (rv && rr) begin
            rr <= 0;
            chk(nm, rdata, e);
            chk("rresp", rresp, exp_resp(a));
         end
      end
      tmo(n);
   endtask : axr
////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(posedge clk);
      rst <= 0;
      // the first edge after release still shows the reset value
      repeat (2) @(posedge clk);
      chk("ready", rdy, 1);
      axr(4'h8, 0, "irq_stat");
      axw(4'h6, 32'h0000_0004);
      axr(4'h6, 0, "unmapped");
      axw(4'hC, 32'h0000_0005);
      axr(4'hC, 32'h0000_0005, "irq_mask");
      axw(4'h0, 32'h0000_0001);
      repeat (3) @(posedge clk);
      chk("int_a", ia, 0);
      req <= 3'h1;
      repeat (3) @(posedge clk);
      req <= 0;
      repeat (3) @(posedge clk);
      chk("int_a", ia, 1);
      chk("irq", irq, 1);
      axr(4'h8, 32'h0000_0001, "irq_stat");
      repeat (2) @(posedge clk);
      chk("irq", irq, 0);
      for (int m = 0; m < 2; m++) begin
         hms <= m[0];
         slow <= m[0];
         axw(4'h0, 0);
         axw(4'h0, 32'h0000_0002);
         req <= 3'h4;
         @(posedge clk);
         req <= 0;
         repeat (4) @(posedge clk);
         chk("int_b", ib, m[0]);
         axr(4'h8, m[0] ? 0 : 4, "irq_stat");
      end
      repeat (16) begin
         seed = lfsr(seed);
         {hms, ext, odn} <= seed[2:0];
         repeat (2) @(posedge clk);
         chk("ready_oe", rdy_oe, seed[0] && !seed[1]);
         chk("int_oe", {ia_oe, ib_oe}, {2{seed[0] && !seed[2]}});
      end
      {hms, ext, odn} <= 3'h1;
      axw(4'h0, 32'h0000_0005);
      repeat (3) @(posedge clk);
      chk("ready", rdy, 0);
      chk("int_a", ia, 0);
      prn <= 0;
      repeat (2) @(posedge clk);
      chk("sub_rst", sub, 1);
      prn <= 1;
      repeat (3) @(posedge clk);
      chk("ready", rdy, 1);
      chk("int_a", ia, 1);
      chk("sub_rst", sub, 0);
      axr(4'h0, 0, "ctrl");
      final_report();
   end
endmodule : testbench

`default_nettype wire
